// File: rtl/acs_pkg.sv
// package: register map, field layout and variant masks of the scan and charge-link select block
`default_nettype none
package acs_pkg;

    // ------------------------------------------------------------
    // register byte offsets (aligned words on the bus)
    // ------------------------------------------------------------
    localparam logic [7:0] off_scan_mask_low         = 8'h00;
    localparam logic [7:0] off_scan_mask_high        = 8'h04;
    localparam logic [7:0] off_charge_link_mask_low  = 8'h08;
    localparam logic [7:0] off_charge_link_mask_high = 8'h0c;

    // ------------------------------------------------------------
    // implemented bits of each word (full package)
    // ------------------------------------------------------------
    localparam logic [15:0] impl_scan_high   = 16'h7cff;
    localparam logic [15:0] impl_scan_low    = 16'hffff;
    localparam logic [15:0] impl_charge_high = 16'h00ff;
    localparam logic [15:0] impl_charge_low  = 16'hffff;

    // variant removals: channels 20..19 live in bits 4..3 of the high words
    localparam logic [15:0] drop_small_high  = 16'h0018;
    localparam logic [15:0] drop_small_low   = 16'h01e0;
    localparam logic [15:0] drop_mid_low     = 16'h01c0;

    localparam logic [15:0] mask_reset_value = 16'h0000;
    localparam logic [31:0] prdata_reset     = 32'h0000_0000;

    // ------------------------------------------------------------
    // package variants and carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        acs_variant_large = 2'h0,
        acs_variant_mid   = 2'h1,
        acs_variant_small = 2'h2
    } acs_variant_type;

    typedef struct packed {
        logic [30:0] scan_include_bits;
        logic [23:0] charge_link_bits;
    } acs_select_type;

endpackage : acs_pkg
`default_nettype wire

// File: rtl/acs_select.sv
// design: apb register block holding the scan-include and charge-link channel masks
// Function
// - high scan word: bits14-10 ch30-26, 7-0 ch23-16
// - low scan word maps inputs 15..0 directly
// - charge-link bit attaches unit to channel
// - non-function bits read back as zero
// - absent variant channels read as zero
// - small package drops channels 20-19, 8-5
// - mid package drops channels 8-6
//
// The address map and the APB slave port were chosen for this implementation.
`default_nettype none
module acs_select #(
    parameter acs_pkg::acs_variant_type variant = acs_pkg::acs_variant_large
) (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // mask outputs to sequencer and charge-time unit
    output var  acs_pkg::acs_select_type select_out
);

    // ------------------------------------------------------------
    // variant masks
    // ------------------------------------------------------------
    function automatic logic [15:0] keep_bits(input logic [15:0] impl, input logic [15:0] drop_small,
                                              input logic [15:0] drop_mid);
        logic [15:0] k;
        k = impl;
        if (variant == acs_pkg::acs_variant_small) begin
            k = impl & ~drop_small;
        end else if (variant == acs_pkg::acs_variant_mid) begin
            k = impl & ~drop_mid;
        end
        return k;
    endfunction : keep_bits

    localparam logic [15:0] keep_scan_high   = keep_bits(acs_pkg::impl_scan_high, acs_pkg::drop_small_high,
                                                         16'h0000);
    localparam logic [15:0] keep_scan_low    = keep_bits(acs_pkg::impl_scan_low, acs_pkg::drop_small_low,
                                                         acs_pkg::drop_mid_low);
    localparam logic [15:0] keep_charge_high = keep_bits(acs_pkg::impl_charge_high, acs_pkg::drop_small_high,
                                                         16'h0000);
    localparam logic [15:0] keep_charge_low  = keep_bits(acs_pkg::impl_charge_low, acs_pkg::drop_small_low,
                                                         acs_pkg::drop_mid_low);

    // write merge honouring byte strobes
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st,
                                          input logic [15:0] keep);
        logic [15:0] n;
        n = old;
        if (st[0]) begin
            n[7:0] = wd[7:0];
        end
        if (st[1]) begin
            n[15:8] = wd[15:8];
        end
        return n & keep;
    endfunction : merge

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] scan_mask_high;
    logic [15:0] scan_mask_low;
    logic [15:0] charge_link_mask_high;
    logic [15:0] charge_link_mask_low;
    logic        wr_access;
    logic        rd_setup;
    logic        addr_hit;
    logic [31:0] next_prdata;

    assign wr_access = psel && penable && pwrite && pready;
    assign rd_setup  = psel && !penable && !pwrite;
    assign addr_hit  = (paddr == acs_pkg::off_scan_mask_low) || (paddr == acs_pkg::off_scan_mask_high) ||
                       (paddr == acs_pkg::off_charge_link_mask_low) || (paddr == acs_pkg::off_charge_link_mask_high);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_mask_low <= acs_pkg::mask_reset_value;
        end else if (wr_access && paddr == acs_pkg::off_scan_mask_low) begin
            scan_mask_low <= merge(scan_mask_low, pwdata, pstrb, keep_scan_low);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_mask_high <= acs_pkg::mask_reset_value;
        end else if (wr_access && paddr == acs_pkg::off_scan_mask_high) begin
            scan_mask_high <= merge(scan_mask_high, pwdata, pstrb, keep_scan_high);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charge_link_mask_low <= acs_pkg::mask_reset_value;
        end else if (wr_access && paddr == acs_pkg::off_charge_link_mask_low) begin
            charge_link_mask_low <= merge(charge_link_mask_low, pwdata, pstrb, keep_charge_low);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charge_link_mask_high <= acs_pkg::mask_reset_value;
        end else if (wr_access && paddr == acs_pkg::off_charge_link_mask_high) begin
            charge_link_mask_high <= merge(charge_link_mask_high, pwdata, pstrb, keep_charge_high);
        end
    end

    // ------------------------------------------------------------
    // bus answer: one wait-free access phase, read data latched in setup
    // ------------------------------------------------------------
    always_comb begin
        next_prdata = prdata;
        if (rd_setup) begin
            unique case (paddr)
                acs_pkg::off_scan_mask_low:         next_prdata = {16'h0000, scan_mask_low};
                acs_pkg::off_scan_mask_high:        next_prdata = {16'h0000, scan_mask_high};
                acs_pkg::off_charge_link_mask_low:  next_prdata = {16'h0000, charge_link_mask_low};
                acs_pkg::off_charge_link_mask_high: next_prdata = {16'h0000, charge_link_mask_high};
                default:                            next_prdata = acs_pkg::prdata_reset;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= acs_pkg::prdata_reset;
        end else begin
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_hit;
        end
    end

    // ------------------------------------------------------------
    // mask outputs, registered from the stored words
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_out <= '0;
        end else begin
            select_out.scan_include_bits <= {scan_mask_high[14:10], 2'b00, scan_mask_high[7:0],
                                             scan_mask_low};
            select_out.charge_link_bits  <= {charge_link_mask_high[7:0], charge_link_mask_low};
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_scan_high_map: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 select_out.scan_include_bits[30:16] == {$past(scan_mask_high[14:10]), 2'b00, $past(scan_mask_high[7:0])})
        else $error("scan high word map wrong");
    chk_scan_low_map: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 select_out.scan_include_bits[15:0] == $past(scan_mask_low))
        else $error("scan low word map wrong");
    chk_charge_map: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 select_out.charge_link_bits == {$past(charge_link_mask_high[7:0]), $past(charge_link_mask_low)})
        else $error("charge link map wrong");
    chk_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
        scan_mask_high[15] == 1'b0 && scan_mask_high[9:8] == 2'b00 && charge_link_mask_high[15:8] == 8'h00)
        else $error("non-function bit set");
    chk_variant_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (scan_mask_low & ~keep_scan_low) == 16'h0000 && (charge_link_mask_low & ~keep_charge_low) == 16'h0000 &&
        (scan_mask_high & ~keep_scan_high) == 16'h0000 && (charge_link_mask_high & ~keep_charge_high) == 16'h0000)
        else $error("absent channel bit set");
    chk_small_drop: assert property (@(posedge pclk) disable iff (!presetn)
        variant == acs_pkg::acs_variant_small |-> select_out.scan_include_bits[20:19] == 2'b00 &&
        select_out.scan_include_bits[8:5] == 4'h0 && select_out.charge_link_bits[8:5] == 4'h0)
        else $error("small variant bit set");
    chk_mid_drop: assert property (@(posedge pclk) disable iff (!presetn)
        variant == acs_pkg::acs_variant_mid |-> select_out.scan_include_bits[8:6] == 3'h0 &&
        select_out.charge_link_bits[8:6] == 3'h0)
        else $error("mid variant bit set");
    chk_reset_clear: assert property (@(posedge pclk)
        !presetn |=> scan_mask_low == 16'h0000 && charge_link_mask_low == 16'h0000)
        else $error("reset did not clear");
    chk_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && paddr == acs_pkg::off_scan_mask_low && pstrb == 4'hf |=>
        scan_mask_low == ($past(pwdata[15:0]) & keep_scan_low))
        else $error("write not stored");

    // ------------------------------------------------------------
    // checks: readback through the bus
    // ------------------------------------------------------------
    chk_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        prdata[31:16] == 16'h0000)
        else $error("read data upper half set");
    chk_read_scan_low: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !pwrite && paddr == acs_pkg::off_scan_mask_low |->
        prdata == {16'h0000, scan_mask_low})
        else $error("scan low readback wrong");
    chk_read_scan_high: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !pwrite && paddr == acs_pkg::off_scan_mask_high |->
        prdata == {16'h0000, scan_mask_high})
        else $error("scan high readback wrong");
    chk_read_charge_low: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !pwrite && paddr == acs_pkg::off_charge_link_mask_low |->
        prdata == {16'h0000, charge_link_mask_low})
        else $error("charge low readback wrong");
    chk_read_charge_high: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !pwrite && paddr == acs_pkg::off_charge_link_mask_high |->
        prdata == {16'h0000, charge_link_mask_high})
        else $error("charge high readback wrong");

    // ------------------------------------------------------------
    // checks: words hold between writes
    // ------------------------------------------------------------
    chk_scan_low_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_access && paddr == acs_pkg::off_scan_mask_low) |=>
        $stable(scan_mask_low))
        else $error("scan low changed without write");
    chk_scan_high_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_access && paddr == acs_pkg::off_scan_mask_high) |=>
        $stable(scan_mask_high))
        else $error("scan high changed without write");
    chk_charge_low_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_access && paddr == acs_pkg::off_charge_link_mask_low) |=>
        $stable(charge_link_mask_low))
        else $error("charge low changed without write");
    chk_charge_high_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_access && paddr == acs_pkg::off_charge_link_mask_high) |=>
        $stable(charge_link_mask_high))
        else $error("charge high changed without write");

    // ------------------------------------------------------------
    // checks: writes and byte lanes
    // ------------------------------------------------------------
    chk_write_scan_high: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && paddr == acs_pkg::off_scan_mask_high && pstrb == 4'hf |=>
        scan_mask_high == ($past(pwdata[15:0]) & keep_scan_high))
        else $error("scan high write not stored");
    chk_write_charge_low: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && paddr == acs_pkg::off_charge_link_mask_low && pstrb == 4'hf |=>
        charge_link_mask_low == ($past(pwdata[15:0]) & keep_charge_low))
        else $error("charge low write not stored");
    chk_write_charge_high: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && paddr == acs_pkg::off_charge_link_mask_high && pstrb == 4'hf |=>
        charge_link_mask_high == ($past(pwdata[15:0]) & keep_charge_high))
        else $error("charge high write not stored");
    chk_write_lane_low: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && paddr == acs_pkg::off_scan_mask_low && pstrb[1:0] == 2'h1 |=>
        scan_mask_low[15:8] == $past(scan_mask_low[15:8]) &&
        scan_mask_low[7:0] == ($past(pwdata[7:0]) & keep_scan_low[7:0]))
        else $error("scan low lane write wrong");

    // ------------------------------------------------------------
    // checks: variants and reset
    // ------------------------------------------------------------
    chk_small_regs: assert property (@(posedge pclk) disable iff (!presetn)
        variant == acs_pkg::acs_variant_small |->
        scan_mask_high[4:3] == 2'h0 && charge_link_mask_high[4:3] == 2'h0 &&
        scan_mask_low[8:5] == 4'h0 && charge_link_mask_low[8:5] == 4'h0)
        else $error("small variant register bit set");
    chk_mid_regs: assert property (@(posedge pclk) disable iff (!presetn)
        variant == acs_pkg::acs_variant_mid |->
        scan_mask_low[8:6] == 3'h0 && charge_link_mask_low[8:6] == 3'h0)
        else $error("mid variant register bit set");
    chk_reset_clear_high: assert property (@(posedge pclk)
        !presetn |=> scan_mask_high == 16'h0000 && charge_link_mask_high == 16'h0000)
        else $error("reset did not clear high words");
    chk_reset_outputs: assert property (@(posedge pclk)
        !presetn |=>
        select_out == '0 && prdata == acs_pkg::prdata_reset && !pready && !pslverr)
        else $error("outputs not cleared in reset");
    chk_select_gap: assert property (@(posedge pclk) disable iff (!presetn)
        select_out.scan_include_bits[25:24] == 2'h0)
        else $error("scan gap bits set");
    chk_charge_out_absent: assert property (@(posedge pclk) disable iff (!presetn)
        (select_out.charge_link_bits[15:0] & ~keep_charge_low) == 16'h0000 &&
        (select_out.charge_link_bits[23:16] & ~keep_charge_high[7:0]) == 8'h00)
        else $error("absent charge channel selected");
    chk_scan_out_absent: assert property (@(posedge pclk) disable iff (!presetn)
        (select_out.scan_include_bits[15:0] & ~keep_scan_low) == 16'h0000)
        else $error("absent scan channel selected");

    cov_write_scan: cover property (@(posedge pclk) disable iff (!presetn)
        wr_access && paddr == acs_pkg::off_scan_mask_high);
    cov_write_charge: cover property (@(posedge pclk) disable iff (!presetn)
        wr_access && paddr == acs_pkg::off_charge_link_mask_low);
    cov_read_back: cover property (@(posedge pclk) disable iff (!presetn) rd_setup ##1 pready);
    cov_bad_addr: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
    cov_strobe_write: cover property (@(posedge pclk) disable iff (!presetn) wr_access && pstrb != 4'hf);

endmodule : acs_select
`default_nettype wire

// File: testbench/adc_scan_and_charge_link_select_tb_top.sv
// testbench: apb register tests of the scan and charge-link select block in all three package variants
`default_nettype none
module adc_scan_and_charge_link_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                    pclk, presetn, psel, penable, pwrite;
    logic [7:0]              paddr;
    logic [31:0]             pwdata;
    logic [3:0]              pstrb, strb;
    logic [31:0]             prdata [3];
    logic                    pready [3];
    logic                    pslverr [3];
    acs_pkg::acs_select_type select_out [3];
    logic [31:0]             got [3];
    logic                    got_err [3];
    logic [15:0]             m [3][4];
    int                      bad_count, cmp_count;
    localparam acs_pkg::acs_variant_type vars [3] = '{acs_pkg::acs_variant_large,
        acs_pkg::acs_variant_mid, acs_pkg::acs_variant_small};
    localparam logic [7:0]  offs [4] = '{acs_pkg::off_scan_mask_low, acs_pkg::off_scan_mask_high,
        acs_pkg::off_charge_link_mask_low, acs_pkg::off_charge_link_mask_high};
    localparam logic [31:0] pats [3] = '{32'hffff_ffff, 32'h1234_a5c3, 32'h0000_5a3c};

    // one instance per package variant, sharing the bus inputs
    for (genvar i = 0; i < 3; i++) begin : g_var
        acs_select #(.variant(vars[i])) DUT (
            .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
            .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata[i]), .pready(pready[i]),
            .pslverr(pslverr[i]), .select_out(select_out[i]));
    end

    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    function automatic logic [15:0] keep(input int v, input int r);
        logic [15:0] k;
        k = (r == 0) ? acs_pkg::impl_scan_low : (r == 1) ? acs_pkg::impl_scan_high :
            (r == 2) ? acs_pkg::impl_charge_low : acs_pkg::impl_charge_high;
        if (v == 2) k = k & ~((r % 2 == 1) ? acs_pkg::drop_small_high : acs_pkg::drop_small_low);
        if (v == 1 && r % 2 == 0) k = k & ~acs_pkg::drop_mid_low;
        return k;
    endfunction : keep

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask : chk

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready[0] !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            $display("[FAIL] %0t no ready", $time);
        end
        for (int v = 0; v < 3; v++) begin
            got[v]     = prdata[v];
            got_err[v] = pslverr[v];
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input int r, input logic [31:0] d);
        xfer(1'b1, offs[r], d);
        for (int v = 0; v < 3; v++) begin
            m[v][r] = d[15:0] & keep(v, r);
            chk({31'h0, got_err[v]}, 32'h0, "write error flag");
        end
    endtask : wr

    task automatic rd(input int r);
        xfer(1'b0, offs[r], 32'h0);
        for (int v = 0; v < 3; v++) begin
            chk(got[v], {16'h0000, m[v][r]}, "readback");
            chk({31'h0, got_err[v]}, 32'h0, "read error flag");
        end
    endtask : rd

    task automatic sel_chk();
        for (int v = 0; v < 3; v++) begin
            chk({1'b0, select_out[v].scan_include_bits},
                {1'b0, m[v][1][14:10], 2'b00, m[v][1][7:0], m[v][0]}, "scan out");
            chk({8'h00, select_out[v].charge_link_bits}, {8'h00, m[v][3][7:0], m[v][2]}, "charge out");
        end
    endtask : sel_chk

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        strb = 4'hf;
        bad_count = 0;
        cmp_count = 0;
        for (int v = 0; v < 3; v++) for (int r = 0; r < 4; r++) m[v][r] = 16'h0000;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int r = 0; r < 4; r++) rd(r);
        sel_chk();
        $display("test reset values done");
        for (int p = 0; p < 3; p++) begin
            for (int r = 0; r < 4; r++) wr(r, pats[p]);
            for (int r = 0; r < 4; r++) rd(r);
            sel_chk();
        end
        $display("test mask patterns done");
        strb = 4'h1;
        for (int r = 0; r < 4; r++) xfer(1'b1, offs[r], 32'hffff_ffc3);
        strb = 4'hf;
        for (int v = 0; v < 3; v++) for (int r = 0; r < 4; r++) m[v][r] = {m[v][r][15:8], 8'hc3} & keep(v, r);
        for (int r = 0; r < 4; r++) rd(r);
        sel_chk();
        $display("test byte lanes done");
        for (int r = 0; r < 4; r++) wr(r, {16'h0000, keep(2, r)});
        for (int r = 0; r < 4; r++) rd(r);
        sel_chk();
        $display("test legal channel set done");
        xfer(1'b1, 8'h10, 32'hffff_ffff);
        for (int v = 0; v < 3; v++) chk({31'h0, got_err[v]}, 32'h1, "unmapped write flag");
        xfer(1'b0, 8'h10, 32'h0);
        for (int v = 0; v < 3; v++) chk(got[v] | {31'h0, ~got_err[v]}, 32'h0, "unmapped read");
        for (int r = 0; r < 4; r++) rd(r);
        $display("test unmapped address done");
        @(posedge pclk);
        presetn <= 1'b0;
        for (int v = 0; v < 3; v++) for (int r = 0; r < 4; r++) m[v][r] = 16'h0000;
        repeat (2) @(posedge pclk);
        sel_chk();
        presetn <= 1'b1;
        for (int r = 0; r < 4; r++) rd(r);
        $display("test mid-run reset done");
        finish_test();
    end

    initial begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end

endmodule : adc_scan_and_charge_link_select_tb_top
`default_nettype wire
